// ==== lsd_sensor.v ====
// Digital drive and readout timing of a linear photodiode array sensor
`timescale 1ns/1ps
`include "lsd_defines.vh"
// Notes on behaviour
// - Pixel shift register advances on the supplied sensor clock.
// - Reset input clears every amplifier integrator before integration.
// - Reset pulse width is the integration period.
// - Conversion strobe output is active high, marks pixel ready.
// - Pixels come out serially, value grows with charge.
// - Pixel rate derives directly from the supplied clock.
// - Works with reset edges aligned or not aligned to clock.
// - Aligned rising edge: integration starts on next clock fall.
// - Unaligned rising edge: integration starts on second clock fall.
// - Aligned falling edge: integration ends on next clock fall.
// - Unaligned falling edge: integration ends on second clock fall.
// - One pixel every eight sensor clock periods.
module lsd_sensor (
	clk,
	rst,
	sensor_clk,
	amp_reset_level,
	pixel_charge,
	video_out,
	video_valid,
	conversion_strobe,
	integrating,
	pixel_index,
	scan_active,
	scan_overrun
);
	input  wire                      clk;
	input  wire                      rst;
	input  wire                      sensor_clk;
	input  wire                      amp_reset_level;
	input  wire [`LSD_PIX_W-1:0]     pixel_charge;
	output reg  [`LSD_PIX_W-1:0]     video_out;
	output reg                       video_valid;
	output reg                       conversion_strobe;
	output reg                       integrating;
	output reg  [`LSD_PIX_IDX_W-1:0] pixel_index;
	output reg                       scan_active;
	output reg                       scan_overrun;

	localparam ST_IDLE = 2'b00;
	localparam ST_LEAD = 2'b01;
	localparam ST_READ = 2'b10;

	// Minimum reset width in system clocks, rounded up
	localparam integer RST_MIN_CYC = (`LSD_RST_MIN_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS;

	// Synchronisers for the pin inputs
	reg        sclk_s1_reg;
	reg        sclk_s2_reg;
	reg        sclk_d_reg;
	reg        rin_s1_reg;
	reg        rin_s2_reg;
	reg        rin_d_reg;
	wire       sclk_fall;
	wire       rin_rise;
	wire       rin_fall;

	// Integration edge tracking
	reg [1:0]  start_cnt_reg;
	reg [1:0]  stop_cnt_reg;
	reg        charge_cleared_reg;

	// Readout sequencing
	reg [1:0]                  state_reg;
	reg [3:0]                  lead_cnt_reg;
	reg [2:0]                  phase_reg;
	reg [`LSD_PIX_IDX_W-1:0]   shift_pos_reg;
	reg [`LSD_PIX_W-1:0]       integ_reg;
	reg [12:0]                 rst_width_reg;
	reg                        push_reg;
	reg [`LSD_PIX_W-1:0]       push_data_reg;

	wire                       fifo_in_ready;
	wire                       fifo_out_valid;
	wire [`LSD_PIX_W-1:0]      fifo_out_data;

	// Saturating add: output grows with charge and clips at full scale
	function [`LSD_PIX_W-1:0] sat_add;
		input [`LSD_PIX_W-1:0] a;
		input [`LSD_PIX_W-1:0] b;
		reg   [`LSD_PIX_W:0]   s;
		begin
			s = {1'b0, a} + {1'b0, b};
			sat_add = s[`LSD_PIX_W] ? {`LSD_PIX_W{1'b1}} : s[`LSD_PIX_W-1:0];
		end
	endfunction

	//--------------------------------------------------------------
	// Pin input synchronisation
	//--------------------------------------------------------------
	// Two flops per pin, then an edge register reading stage two
	always @(posedge clk) begin
		if (rst) begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_d_reg  <= 1'b0;
			rin_s1_reg  <= 1'b0;
			rin_s2_reg  <= 1'b0;
			rin_d_reg   <= 1'b0;
		end else begin
			sclk_s1_reg <= sensor_clk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_d_reg  <= sclk_s2_reg;
			rin_s1_reg  <= amp_reset_level;
			rin_s2_reg  <= rin_s1_reg;
			rin_d_reg   <= rin_s2_reg;
		end
	end

	assign sclk_fall = sclk_d_reg && !sclk_s2_reg;
	assign rin_rise  = !rin_d_reg && rin_s2_reg;
	assign rin_fall  = rin_d_reg && !rin_s2_reg;

	//--------------------------------------------------------------
	// Integration window
	//--------------------------------------------------------------
	// A reset edge seen together with a clock fall counts as aligned and
	// waits for one more fall; otherwise it waits for two.
	always @(posedge clk) begin
		if (rst) begin
			start_cnt_reg      <= 2'h0;
			stop_cnt_reg       <= 2'h0;
			integrating        <= 1'b0;
			charge_cleared_reg <= 1'b0;
			rst_width_reg      <= 13'h0000;
			scan_overrun       <= 1'b0;
		end else begin
			if (rin_rise) begin
				start_cnt_reg <= sclk_fall ? 2'h1 : 2'h2;
				stop_cnt_reg  <= 2'h0;
				charge_cleared_reg <= 1'b1;
			end else if (sclk_fall && start_cnt_reg != 2'h0) begin
				start_cnt_reg <= start_cnt_reg - 2'h1;
				if (start_cnt_reg == 2'h1)
					integrating <= 1'b1;
			end
			if (rin_fall) begin
				stop_cnt_reg  <= sclk_fall ? 2'h1 : 2'h2;
				start_cnt_reg <= 2'h0;
			end else if (sclk_fall && stop_cnt_reg != 2'h0) begin
				stop_cnt_reg <= stop_cnt_reg - 2'h1;
				if (stop_cnt_reg == 2'h1) begin
					integrating        <= 1'b0;
					charge_cleared_reg <= 1'b0;
				end
			end
			// Width of the reset pulse, saturating, for overrun flag
			// The cycle that sees the rise is the first high cycle of the pulse
			if (rin_rise)
				rst_width_reg <= 13'h0001;
			else if (rin_s2_reg && rst_width_reg != 13'h1FFF)
				rst_width_reg <= rst_width_reg + 13'h0001;
			// Flag a new reset arriving mid scan or a short pulse
			if (rin_rise && state_reg != ST_IDLE)
				scan_overrun <= 1'b1;
			else if (rin_fall && rst_width_reg < RST_MIN_CYC[12:0])
				scan_overrun <= 1'b1;
			else if (rin_rise)
				scan_overrun <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Charge integration model
	//--------------------------------------------------------------
	// Accumulates charge per clock fall while integrating, cleared by reset
	always @(posedge clk) begin
		if (rst || (rin_rise && !integrating))
			integ_reg <= {`LSD_PIX_W{1'b0}};
		else if (integrating && sclk_fall)
			integ_reg <= sat_add(integ_reg, pixel_charge);
	end

	//--------------------------------------------------------------
	// Readout sequencer
	//--------------------------------------------------------------
	// After integration ends: ten lead clocks, then eight clocks per pixel
	always @(posedge clk) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			lead_cnt_reg  <= 4'h0;
			phase_reg     <= 3'h0;
			shift_pos_reg <= {`LSD_PIX_IDX_W{1'b0}};
			push_reg      <= 1'b0;
			push_data_reg <= {`LSD_PIX_W{1'b0}};
			scan_active   <= 1'b0;
		end else begin
			if (push_reg && fifo_in_ready)
				push_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (sclk_fall && stop_cnt_reg == 2'h1) begin
						state_reg     <= ST_LEAD;
						lead_cnt_reg  <= 4'h1;
						shift_pos_reg <= {`LSD_PIX_IDX_W{1'b0}};
						scan_active   <= 1'b1;
					end
				end
				ST_LEAD: begin
					if (sclk_fall) begin
						if (lead_cnt_reg == `LSD_LEAD_CLKS) begin
							state_reg <= ST_READ;
							phase_reg <= 3'h0;
						end
						lead_cnt_reg <= lead_cnt_reg + 4'h1;
					end
				end
				ST_READ: begin
					// Stall the shift register until the FIFO accepts the pending sample
					if (sclk_fall && !push_reg) begin
						phase_reg <= phase_reg + 3'h1;
						if (phase_reg == `LSD_CLK_PER_PIX) begin
							push_reg      <= 1'b1;
							push_data_reg <= integ_reg;
							if (shift_pos_reg == `LSD_NUM_PIX - 9'h001) begin
								state_reg   <= ST_IDLE;
								scan_active <= 1'b0;
							end
							shift_pos_reg <= shift_pos_reg + 9'h001;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	//--------------------------------------------------------------
	// Pixel buffer
	//--------------------------------------------------------------
	lsd_fifo #(
		.WIDTH (`LSD_PIX_W),
		.DEPTH (`LSD_FIFO_DEPTH),
		.AW    (`LSD_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_reg),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out_data),
		.flush     (1'b0)
	);

	//--------------------------------------------------------------
	// Video output and conversion strobe
	//--------------------------------------------------------------
	// Strobe pulses one cycle with each new sample on the video output
	always @(posedge clk) begin
		if (rst) begin
			video_out         <= {`LSD_PIX_W{1'b0}};
			video_valid       <= 1'b0;
			conversion_strobe <= 1'b0;
			pixel_index       <= {`LSD_PIX_IDX_W{1'b0}};
		end else begin
			video_valid       <= fifo_out_valid;
			conversion_strobe <= fifo_out_valid;
			if (fifo_out_valid) begin
				video_out <= fifo_out_data;
				pixel_index <= pixel_index + 9'h001;
			end else if (rin_rise) begin
				pixel_index <= {`LSD_PIX_IDX_W{1'b0}};
			end
		end
	end
endmodule // lsd_sensor

// ==== lsd_defines.vh ====
// Constants for the linear sensor drive timing block
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH
`define LSD_PIX_W         12
`define LSD_NUM_PIX       9'h100
`define LSD_PIX_IDX_W     9
`define LSD_CLK_PER_PIX   3'h7
`define LSD_LEAD_CLKS     4'hA
`define LSD_RST_MIN_NS    6000
`define LSD_CLK_NS        25
`define LSD_FIFO_DEPTH    16
`define LSD_FIFO_AW       4
`endif

// ==== lsd_fifo.v ====
// Small synchronous FIFO holding pixel samples ahead of the video output
`timescale 1ns/1ps
module lsd_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output reg              out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data,
	input  wire             flush
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	// Handshakes; output register reloads when empty or drained
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign push     = in_valid && in_ready;
	assign pop      = (count_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);

	// Storage and pointers
	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
		if (rst || flush) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			out_valid  <= 1'b0;
			out_data   <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
				out_data   <= mem[rd_ptr_reg];
				out_valid  <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !pop)
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			else if (pop && !push)
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // lsd_fifo

// ==== lsd_pulse_gen.sv ====
// Pulse generator model driving the sensor clock and reset pins
`timescale 1ns/1ps
module lsd_pulse_gen (
	input  wire        clk,
	input  wire        rst,
	input  wire        go,
	input  wire [15:0] width,
	input  wire [2:0]  offs,
	output reg         sensor_clk,
	output reg         amp_reset_level
);
	reg  [2:0]  ph_reg;
	reg  [15:0] cnt_reg;
	reg         armed_reg;
	wire [2:0]  ph_next = ph_reg + 3'h1;
	wire [2:0]  go_ph   = 3'h3 + offs;

	// Free sensor clock of eight system clocks; reset pulse placed at an offset to its fall
	always @(posedge clk) begin
		if (rst) begin
			ph_reg <= 3'h0;
			sensor_clk <= 1'b1;
			amp_reset_level <= 1'b0;
			armed_reg <= 1'b0;
			cnt_reg <= 16'h0;
		end else begin
			ph_reg <= ph_next;
			sensor_clk <= ~ph_next[2];
			if (go)
				armed_reg <= 1'b1;
			if (armed_reg && ph_reg == go_ph) begin
				amp_reset_level <= 1'b1;
				armed_reg <= 1'b0;
				cnt_reg <= width - 16'h1;
			end else if (amp_reset_level) begin
				if (cnt_reg == 16'h0)
					amp_reset_level <= 1'b0;
				else
					cnt_reg <= cnt_reg - 16'h1;
			end
		end
	end
endmodule // lsd_pulse_gen

// ==== lsd_sensor_asserts.sv ====
// Assertion checker for the linear sensor drive block
`timescale 1ns/1ps
`include "lsd_defines.vh"
module lsd_sensor_chk (
	input wire                      clk,
	input wire                      rst,
	input wire                      sensor_clk,
	input wire                      amp_reset_level,
	input wire [`LSD_PIX_W-1:0]     pixel_charge,
	input wire [`LSD_PIX_W-1:0]     video_out,
	input wire                      video_valid,
	input wire                      conversion_strobe,
	input wire                      integrating,
	input wire [`LSD_PIX_IDX_W-1:0] pixel_index,
	input wire                      scan_active,
	input wire                      scan_overrun
);
	reg       sc_q, ar_q, int_q, co;
	reg [1:0] e_cnt;
	reg [4:0] f_cnt;
	wire      sfall = sc_q & ~sensor_clk;

	// Count sensor clock falls since a reset pin edge and since the last sample or integration end
	always @(posedge clk) begin
		if (rst) begin
			sc_q <= 1'b1;
			ar_q <= 1'b0;
			int_q <= 1'b0;
			co <= 1'b0;
			e_cnt <= 2'h0;
			f_cnt <= 5'h0;
		end else begin
			sc_q <= sensor_clk;
			ar_q <= amp_reset_level;
			int_q <= integrating;
			if (ar_q != amp_reset_level) begin
				e_cnt <= 2'h0;
				co <= sfall;
			end else if (sfall && e_cnt != 2'h3)
				e_cnt <= e_cnt + 2'h1;
			if (conversion_strobe || (int_q && !integrating))
				f_cnt <= 5'h0;
			else if (sfall && f_cnt != 5'h1F)
				f_cnt <= f_cnt + 5'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_pulse_rise;
		$rose(amp_reset_level) ##0 !scan_active;
	endsequence
	sequence s_int_end;
		integrating ##1 !integrating;
	endsequence

	AST_STROBE_PAIR: assert property (conversion_strobe == video_valid)
		else $error("strobe and valid differ");
	AST_STROBE_PULSE: assert property (conversion_strobe |=> !conversion_strobe)
		else $error("strobe longer than one cycle");
	AST_INDEX_STEP: assert property (conversion_strobe |-> pixel_index == $past(pixel_index) + 9'h1)
		else $error("pixel index did not step");
	AST_PIX_SPACING: assert property (conversion_strobe |->
		f_cnt == ((pixel_index == 9'h1) ? 5'h12 : 5'h08)) else $error("pixel spacing wrong");
	AST_INT_START: assert property ($rose(integrating) |-> e_cnt == (co ? 2'h1 : 2'h2))
		else $error("integration start edge wrong");
	AST_INT_END: assert property ($fell(integrating) |-> e_cnt == (co ? 2'h1 : 2'h2))
		else $error("integration end edge wrong");
	AST_INT_IN_PULSE: assert property ($rose(integrating) |-> amp_reset_level)
		else $error("integration outside reset pulse");
	AST_RISE_BOUND: assert property (s_pulse_rise |-> ##[3:24] integrating)
		else $error("integration did not start");
	AST_FALL_BOUND: assert property ($fell(amp_reset_level) |-> ##[3:24] !integrating)
		else $error("integration did not end");
	AST_SCAN_START: assert property (s_int_end |-> ##[0:2] scan_active)
		else $error("readout did not start");
endmodule // lsd_sensor_chk

bind lsd_sensor lsd_sensor_chk u_chk (.clk(clk), .rst(rst), .sensor_clk(sensor_clk),
	.amp_reset_level(amp_reset_level), .pixel_charge(pixel_charge), .video_out(video_out),
	.video_valid(video_valid), .conversion_strobe(conversion_strobe),
	.integrating(integrating), .pixel_index(pixel_index), .scan_active(scan_active),
	.scan_overrun(scan_overrun));

// ==== tb_linear_sensor_drive_timing.sv ====
// Self-checking bench for the linear sensor drive block
`timescale 1ns/1ps
`include "lsd_defines.vh"
`define CHK(nm, got, exp) begin samples_checked = samples_checked + 1; \
	if ((got) !== (exp)) begin err_total = err_total + 1; \
	$display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module tb_linear_sensor_drive_timing;
	reg         clk, rst, go;
	reg  [15:0] width, rw;
	reg  [2:0]  offs, ro;
	reg  [11:0] charge, rc, v0, v1, v2;
	wire        sensor_clk, amp_reset_level, video_valid, conversion_strobe;
	wire        integrating, scan_active, scan_overrun;
	wire [11:0] video_out;
	wire [8:0]  pixel_index;
	integer     err_total, samples_checked, seed;

	lsd_pulse_gen gen (.clk(clk), .rst(rst), .go(go), .width(width), .offs(offs),
		.sensor_clk(sensor_clk), .amp_reset_level(amp_reset_level));
	lsd_sensor uut (.clk(clk), .rst(rst), .sensor_clk(sensor_clk),
		.amp_reset_level(amp_reset_level), .pixel_charge(charge), .video_out(video_out),
		.video_valid(video_valid), .conversion_strobe(conversion_strobe),
		.integrating(integrating), .pixel_index(pixel_index), .scan_active(scan_active),
		.scan_overrun(scan_overrun));

	// Expected video for a given charge and pulse width, clipped at full scale
	function [11:0] sat_val(input [11:0] c, input [15:0] w);
		reg [31:0] p;
		begin
			p = c * (w >> 3);
			sat_val = (p > 32'hFFF) ? 12'hFFF : p[11:0];
		end
	endfunction

	// One exposure and readout, checking every sample
	task run_scan(input [15:0] w, input [2:0] o, input [11:0] c, output [11:0] v);
		integer n, ilen, k;
		begin
			@(posedge clk);
			go <= 1'b1;
			width <= w;
			offs <= o;
			charge <= c;
			@(posedge clk);
			go <= 1'b0;
			n = 0;
			ilen = 0;
			k = 0;
			v = 12'h0;
			while (n < 256 && k < 20000) begin
				@(negedge clk);
				k = k + 1;
				if (integrating === 1'b1)
					ilen = ilen + 1;
				if (conversion_strobe === 1'b1) begin
					n = n + 1;
					if (n == 1)
						v = video_out;
					else
						`CHK("video_out", video_out, v)
				end
			end
			`CHK("pixels", n, 256)
			`CHK("int_len", ilen, w)
			`CHK("pixel_index", pixel_index, `LSD_NUM_PIX)
			`CHK("overrun", scan_overrun, 1'b0)
			repeat (200) @(negedge clk); // Reset low for 200 clocks after the last sample
			`CHK("scan_active", scan_active, 1'b0)
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d errors %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	always #12.5 clk = ~clk;

	// Dark, saturating and graded exposures, aligned and offset edges
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		go = 1'b0;
		width = 16'hF0;
		offs = 3'h0;
		charge = 12'h0;
		err_total = 0;
		samples_checked = 0;
		seed = 32'h3ECF30D2;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		run_scan(16'hF0, 3'h0, 12'h0, v0); // Shortest pulse
		`CHK("dark", v0, sat_val(12'h0, 16'hF0))
		rw = 16'hF0 + (({$random(seed)} % 16) << 3);
		ro = 3'h1 + {$random(seed)} % 7;
		run_scan(rw, ro, 12'hFFF, v0);
		`CHK("full", v0, sat_val(12'hFFF, rw))
		rc = 12'h1 + {$random(seed)} % 7;
		run_scan(16'hF0, 3'h0, rc, v1);
		run_scan(16'hF0, ro, rc << 1, v2);
		`CHK("cleared", v1, sat_val(rc, 16'hF0))
		`CHK("grows", v2 > v1, 1'b1)
		`CHK("double", v2, sat_val(rc << 1, 16'hF0))
		give_verdict;
	end

	// Watchdog
	initial begin
		#(90000 * 25);
		err_total = err_total + 1;
		give_verdict;
	end
endmodule // tb_linear_sensor_drive_timing
